// *** src/crp_regs.sv ***
// remap table and ch1/ch2 shutdown priority register bank
//
// Overview of operation
// - The remap table is one read/write byte at command 26h.
// - Two-bit fields pick physical channel 1..4, logical ch4 on top.
// - At power-on the remap byte is e4h, the identity mapping.
// - A remap write with any repeated code is rejected and the old map stays.
// - A rejected remap write changes no field at all.
// - A channel reset command at 1Ah leaves the remap table alone.
// - The reset pin keeps the remap byte; only power-on reloads it.
// - At 27h: ch2 prio in 6:4, ch1 in 2:0, bits 7 and 3 unused, reset 0.
// - A shutdown code turns off each channel with priority >= code.
`timescale 1ns/10ps
`include "crp_regs.svh"
module crp_regs
  import crp_pkg::*;
#(
  parameter int NLOG = 4
)
(
  input  wire logic             mclk,            // 100 MHz system clock
  input  wire logic             sys_rst,         // power-on reset, sync high
  input  wire logic             reset_pin_n,     // hardware reset pin, async
  input  wire crp_cmd_t         cmd,             // command from bus front end
  input  wire logic             group_off,       // all group channels off
  input  wire logic             mbit_prty_en,    // 3-bit priority mode on
  input  wire logic [2:0]       serial_shutdown_input, // shutdown code pins
  input  wire logic             shutdown_strobe, // code strobe pin
  output logic                  cmd_hit,         // code belongs to this bank
  output logic      [7:0]       rdata,           // read data
  output logic                  rvalid,          // read data valid pulse
  output logic                  wr_ack,          // write accepted pulse
  output logic                  wr_reject,       // remap write refused pulse
  output crp_remap_t            remap,           // active remap table
  output logic [NLOG-1:0][3:0]  phys_sel,        // one-hot physical per lch
  output crp_prio_t             prio,            // ch1/ch2 priorities
  output logic      [1:0]       ch_off           // turn-off pulse, ch1 bit0
);

  // pin stages start at idle level: no false pin reset after power-on
  localparam crp_state_t ST_RST = '{
    remap:     crp_remap_t'(`CRP_REMAP_RST),
    prio:      crp_prio_t'(`CRP_PRIO_RST),
    rdata:     8'h00,
    rvalid:    1'h0,
    wr_ack:    1'h0,
    wr_reject: 1'h0,
    ch_off:    2'h0,
    rstn_s1:   1'h1,
    rstn_s2:   1'h1,
    stb_s1:    1'h0,
    stb_s2:    1'h0,
    stb_s3:    1'h0,
    code_s1:   3'h0,
    code_s2:   3'h0
  };

  crp_state_t q_ff;
  crp_state_t nxt_q;
  logic [1:0] cmp_off;
  logic       stb_rise;
  logic       pin_rst;
  logic       dup;
  logic       off_fire;
  logic       hit_remap;
  logic       hit_prio;
  crp_remap_t wr_map;

  // any pair of equal codes makes the value illegal
  function automatic logic has_dup(input crp_remap_t m);
    logic [3:0][1:0] f;
    logic            d;
    f = m;
    d = 1'h0;
    for (int a = 0; a < 3; a++)
    begin
      for (int b = a + 1; b < 4; b++)
      begin
        d = d || (f[a] == f[b]);
      end
    end
    return d;
  endfunction

  assign wr_map   = crp_remap_t'(cmd.wdata);
  assign dup      = has_dup(wr_map);
  assign stb_rise = q_ff.stb_s2 && !q_ff.stb_s3;
  assign pin_rst  = !q_ff.rstn_s2;
  assign off_fire = stb_rise && mbit_prty_en;
  assign hit_remap = (cmd.code == `CRP_CMD_REMAP);
  assign hit_prio  = (cmd.code == `CRP_CMD_PRIO12);

  // code pins pass the same two stages as the strobe, so the host must
  // settle the code before raising the strobe
  crp_prio_cmp #(
    .NCH (2)
  ) u_cmp (
    .prio (q_ff.prio),
    .code (q_ff.code_s2),
    .fire (off_fire),
    .off  (cmp_off)
  );

  always_comb
  begin
    cmd_hit = hit_remap || hit_prio;
  end

  always_comb
  begin
    nxt_q = q_ff;
    // third strobe stage only feeds the rising-edge detect
    nxt_q.rstn_s1   = reset_pin_n;
    nxt_q.rstn_s2   = q_ff.rstn_s1;
    nxt_q.stb_s1    = shutdown_strobe;
    nxt_q.stb_s2    = q_ff.stb_s1;
    nxt_q.stb_s3    = q_ff.stb_s2;
    nxt_q.code_s1   = serial_shutdown_input;
    nxt_q.code_s2   = q_ff.code_s1;
    nxt_q.rvalid    = 1'b0;
    nxt_q.wr_ack    = 1'b0;
    nxt_q.wr_reject = 1'b0;
    nxt_q.ch_off    = cmp_off;

    if (cmd.valid)
    begin
      unique case (cmd.code)
        `CRP_CMD_REMAP:
        begin
          if (cmd.write)
          begin
            // refuse whole byte, never a partial field update
            if (dup || !group_off)
            begin
              nxt_q.wr_reject = 1'b1;
            end
            else
            begin
              // a write taken while pin reset is seen still lands
              nxt_q.remap  = wr_map;
              nxt_q.wr_ack = 1'b1;
            end
          end
          else
          begin
            nxt_q.rdata  = q_ff.remap;
            nxt_q.rvalid = 1'b1;
          end
        end
        `CRP_CMD_PRIO12:
        begin
          if (cmd.write)
          begin
            // bits 7 and 3 are not stored and read back as zero
            nxt_q.prio.ch1 = cmd.wdata[`CRP_PRIO_CH1_LSB +: 3];
            nxt_q.prio.ch2 = cmd.wdata[`CRP_PRIO_CH2_LSB +: 3];
            nxt_q.wr_ack   = 1'b1;
          end
          else
          begin
            nxt_q.rdata  = {1'b0, q_ff.prio.ch2, 1'b0, q_ff.prio.ch1}
                           & `CRP_PRIO_RD_MASK;
            nxt_q.rvalid = 1'b1;
          end
        end
        `CRP_CMD_CHRST:
        begin
          // channel reset belongs to the channel logic; map kept as is
          nxt_q.remap = q_ff.remap;
        end
        default:
        begin
          // foreign codes are answered elsewhere; a read here gives zero
          if (!cmd.write)
          begin
            nxt_q.rdata = 8'h00;
          end
        end
      endcase
    end

    // pin reset clears priorities but spares the remap table
    if (pin_rst)
    begin
      nxt_q.prio   = crp_prio_t'(`CRP_PRIO_RST);
      nxt_q.ch_off = 2'b00;
    end
  end

  // sys_rst is power-on, the only event that reloads the identity map
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      q_ff <= ST_RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // select follows the table with no extra cycle of latency
  genvar i;
  generate
    for (i = 0; i < NLOG; i = i + 1)
    begin : g_sel
      assign phys_sel[i] = 4'h1 << q_ff.remap[i*2 +: 2];
    end
  endgenerate

  assign rdata     = q_ff.rdata;
  assign rvalid    = q_ff.rvalid;
  assign wr_ack    = q_ff.wr_ack;
  assign wr_reject = q_ff.wr_reject;
  assign remap     = q_ff.remap;
  assign prio      = q_ff.prio;
  assign ch_off    = q_ff.ch_off;

endmodule

// *** src/crp_regs.svh ***
// command codes, field positions and reset values of the remap/priority bank
`ifndef CRP_REGS_SVH
`define CRP_REGS_SVH

`define CRP_CMD_REMAP     8'h26
`define CRP_CMD_PRIO12    8'h27
`define CRP_CMD_CHRST     8'h1a

`define CRP_REMAP_RST     8'he4
`define CRP_PRIO_RST      8'h00

`define CRP_PRIO_CH1_LSB  0
`define CRP_PRIO_CH2_LSB  4
`define CRP_PRIO_RD_MASK  8'h77

`define CRP_SYNC_STAGES   2

`endif

// *** src/crp_pkg.sv ***
// types shared by the remap and priority register bank
package crp_pkg;

  // one two-bit physical channel code per logical channel, ch4 on top
  typedef struct packed {
    logic [1:0] log4;
    logic [1:0] log3;
    logic [1:0] log2;
    logic [1:0] log1;
  } crp_remap_t;

  typedef struct packed {
    logic [2:0] ch2;
    logic [2:0] ch1;
  } crp_prio_t;

  // one byte-wide command from the serial management front end
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] wdata;
  } crp_cmd_t;

  typedef struct packed {
    crp_remap_t remap;
    crp_prio_t  prio;
    logic [7:0] rdata;
    logic       rvalid;
    logic       wr_ack;
    logic       wr_reject;
    logic [1:0] ch_off;
    logic       rstn_s1;
    logic       rstn_s2;
    logic       stb_s1;
    logic       stb_s2;
    logic       stb_s3;
    logic [2:0] code_s1;
    logic [2:0] code_s2;
  } crp_state_t;

endpackage

// *** src/crp_prio_cmp.sv ***
// per-channel shutdown priority comparator
`timescale 1ns/10ps
module crp_prio_cmp
  import crp_pkg::*;
#(
  parameter int NCH = 2
)
(
  input  wire logic [NCH*3-1:0] prio,     // packed 3-bit priorities, ch1 low
  input  wire logic [2:0]       code,     // received shutdown code
  input  wire logic             fire,     // code is valid this cycle
  output logic      [NCH-1:0]   off       // channel must turn off
);

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1)
    begin : g_ch
      // a lower priority value is kept on; equal or above code drops
      assign off[i] = fire && (code <= prio[i*3 +: 3]);
    end
  endgenerate

endmodule

// *** bench/crp_host_model.sv ***
// host model issuing single byte commands to the bank
`timescale 1ns/10ps
module crp_host
  import crp_pkg::*;
(
  input  wire logic mclk, // clock
  output crp_cmd_t  cmd   // command
);
  // register bytes only: no turn-on, so no detect cycle is owed
  initial cmd = '0;
  // one byte per command, valid for one edge only
  task automatic xfer(input logic w, input logic [7:0] c, d);
    @(negedge mclk);
    cmd = '{1'b1, w, c, d};
    @(negedge mclk);
    cmd = '0;
  endtask
endmodule

// *** bench/crp_regs_checker.sv ***
// port assertions for the remap and priority bank
`timescale 1ns/10ps
module crp_regs_checker
  import crp_pkg::*;
(
  input wire logic       mclk,                  // clk
  input wire logic       sys_rst,               // por
  input wire crp_cmd_t   cmd,                   // cmd
  input wire logic       group_off,             // off
  input wire logic       mbit_prty_en,          // mode
  input wire logic [2:0] serial_shutdown_input, // code
  input wire logic       shutdown_strobe,       // strobe
  input wire logic [7:0] rdata,                 // rd
  input wire logic       rvalid,                // rd ok
  input wire logic       wr_ack,                // ack
  input wire logic       wr_reject,             // nak
  input wire crp_remap_t remap,                 // map
  input wire crp_prio_t  prio,                  // prio
  input wire logic [1:0] ch_off                 // off
);
  logic [7:0] w;
  logic       dup, wr26;
  assign w = cmd.wdata;
  assign wr26 = cmd.valid && cmd.write && cmd.code == 8'h26;
  assign dup = w[1:0] == w[3:2] || w[1:0] == w[5:4] || w[1:0] == w[7:6]
    || w[3:2] == w[5:4] || w[3:2] == w[7:6] || w[5:4] == w[7:6];
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence s_dup_wr;
    wr26 ##0 dup;
  endsequence
  sequence s_hit1;
    $rose(shutdown_strobe) && mbit_prty_en
      && serial_shutdown_input <= prio.ch1;
  endsequence
  a_remap_por: assert property ($fell(sys_rst) |-> remap == 8'he4)
    else $error("remap wrong after reset");
  a_remap_take: assert property (wr26 && !dup && group_off
    |=> wr_ack && remap == $past(w)) else $error("remap write lost");
  a_dup_nak: assert property (s_dup_wr
    |=> wr_reject && $stable(remap)) else $error("duplicate remap taken");
  a_remap_keep: assert property (!wr26 |=> $stable(remap))
    else $error("remap changed without write");
  a_prio_ack: assert property (cmd.valid && cmd.write
    && cmd.code == 8'h27 |=> wr_ack) else $error("prio write not acked");
  a_prio_read: assert property (cmd.valid && !cmd.write
    && cmd.code == 8'h27 |=> rvalid
    && rdata == {1'b0, $past(prio.ch2), 1'b0, $past(prio.ch1)})
    else $error("prio read wrong");
  a_off_hit: assert property (s_hit1 |-> ##[2:5] ch_off[0])
    else $error("ch1 not turned off");
  a_off_cause: assert property (ch_off[0] |-> mbit_prty_en
    && serial_shutdown_input <= prio.ch1) else $error("ch1 off wrongly");
endmodule
bind crp_regs crp_regs_checker chk_u (.mclk, .sys_rst, .cmd, .group_off,
  .mbit_prty_en, .serial_shutdown_input, .shutdown_strobe, .rdata, .rvalid,
  .wr_ack, .wr_reject, .remap, .prio, .ch_off);

// *** bench/crp_regs_tb_top.sv ***
// self-checking bench for the remap and priority bank
`timescale 1ns/10ps
module crp_regs_tb_top;
  import crp_pkg::*;
  localparam logic [10:0] ACK = 11'h100, REJ = 11'h200, RD = 11'h400;
  logic            mclk = 0, sys_rst = 1, reset_pin_n = 1, group_off = 1;
  logic            mbit_prty_en = 1, shutdown_strobe = 0;
  logic [2:0]      serial_shutdown_input = 0;
  logic            cmd_hit, rvalid, wr_ack, wr_reject;
  logic [7:0]      rdata, v, old;
  logic [1:0]      ch_off, seen;
  logic [3:0][3:0] phys_sel;
  logic [10:0]     q[$];
  crp_cmd_t        cmd;
  crp_remap_t      remap;
  crp_prio_t       prio;
  int              fails = 0, n_checks = 0, cyc = 0, seed = 52;
  always #5 mclk = ~mclk;
  crp_host host_u (.mclk(mclk), .cmd(cmd));
  crp_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .cmd(cmd), .group_off(group_off), .mbit_prty_en(mbit_prty_en),
    .serial_shutdown_input(serial_shutdown_input), .cmd_hit(cmd_hit),
    .shutdown_strobe(shutdown_strobe), .rdata(rdata), .rvalid(rvalid),
    .wr_ack(wr_ack), .wr_reject(wr_reject), .remap(remap),
    .phys_sel(phys_sel), .prio(prio), .ch_off(ch_off));
  task automatic chk(input logic [10:0] g, e);
    n_checks++;
    if (g !== e) fails++;
    if (g !== e) $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic op(input logic w, input logic [7:0] c, d, input int e);
    if (e != 0) q.push_back(e[10:0]);
    host_u.xfer(w, c, d);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a pulse is matched to the oldest note
  always @(posedge mclk)
  begin
    #1;
    if (rvalid === 1'b1 || wr_ack === 1'b1 || wr_reject === 1'b1)
      chk({rvalid, wr_reject, wr_ack, rvalid ? rdata : 8'h00},
          q.pop_front());
    if (cmd.valid === 1'b1)
      chk(cmd_hit, cmd.code == 8'h26 || cmd.code == 8'h27);
  end
  always @(posedge mclk)
    if (++cyc == 4000)
    begin
      fails++;
      tally_and_finish;
    end
  initial
  begin
    repeat (6) @(negedge mclk);
    sys_rst = 0;
    // let the pin synchronisers fill before the first command
    repeat (3) @(negedge mclk);
    op(0, 8'h26, 0, RD | 11'he4);
    op(0, 8'h27, 0, RD);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'he4 ^ {4{k[1:0]}};
      op(1, 8'h26, v, ACK);
      op(0, 8'h26, 0, RD | v);
      chk(phys_sel[3], 4'h1 << v[7:6]);
      for (int j = 0; j < 3; j++)
        chk(phys_sel[j], 4'h1 << v[2*j +: 2]);
    end
    old = v;
    repeat (3)
    begin
      v = 8'($random(seed));
      v[3:2] = v[7:6];
      op(1, 8'h26, v, REJ);
      op(0, 8'h26, 0, RD | old);
    end
    group_off = 0;
    op(1, 8'h26, 8'he4, REJ);
    group_off = 1;
    op(1, 8'h1a, 8'hff, 0);
    op(0, 8'h26, 0, RD | old);
    op(0, 8'h28, 0, 0);
    chk(rdata, 8'h00);
    $display("remap tests done");
    op(1, 8'h27, 8'hff, ACK);
    reset_pin_n = 0;
    repeat (5) @(negedge mclk);
    reset_pin_n = 1;
    repeat (3) @(negedge mclk);
    op(0, 8'h26, 0, RD | old);
    op(0, 8'h27, 0, RD);
    repeat (6)
    begin
      v = 8'($random(seed));
      op(1, 8'h27, v, ACK);
      op(0, 8'h27, 0, RD | (v & 8'h77));
    end
    $display("priority tests done");
    op(1, 8'h27, 8'h52, ACK);
    for (int c = 0; c < 9; c++)
    begin
      mbit_prty_en = c < 8;
      serial_shutdown_input = c[2:0];
      repeat (3) @(negedge mclk);
      shutdown_strobe = 1;
      seen = 0;
      repeat (8) @(posedge mclk) #1 seen |= ch_off;
      @(negedge mclk);
      shutdown_strobe = 0;
      chk(seen, c < 8 ? {c <= 5, c <= 2} : 2'b00);
    end
    $display("shutdown tests done");
    sys_rst = 1;
    repeat (2) @(negedge mclk);
    sys_rst = 0;
    op(0, 8'h26, 0, RD | 11'he4);
    repeat (3) @(negedge mclk);
    chk(q.size(), 0);
    tally_and_finish;
  end
endmodule
